// [ssp_cfg.svh]
// Constants of the stacked serial packet layer: offsets, fields, reset values.
// Assumes it is included by bare name; holds definitions only.
//
// What this block does
// - Addressed write takes data from host input as base device, else from south input
// - Bad or missing write check asserts south alert
// - Valid-address devices accept broadcast address writes
// - One data byte; first byte address and direction
// - Packet: address, offset, count, data, check byte
// - Check byte is CRC-8, poly 07, MSB first
// - Data supplier appends the check byte
// - Read check covers header and data, not filler
// - Check verified when chip-select ends packet
// - Bad check: discard, flag fault, latch fault
// - Fault flag holds until fault register write or reset
// - Reset clears flag, address, raises south alert
// - Address zero keeps north chip-select low
// - Valid address passes chip-select north
// - Valid addresses run 01 to 3E
// - Zero-address device blocks traffic going north
// - Address write sets assigned bit and clears the unaddressed alert
// - Reserved registers and bits read zero
// - Status registers reinitialised by reset only
// - Write held until check passes, else dropped
// - Serial mode 1, MSB first
// - Host chip-select assert resynchronises the receiver
// - Vertical chip-select is active high
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ---------------------------------------------------------------
// Addressing
// ---------------------------------------------------------------
`define SSP_ADDR_W 6
`define SSP_BCAST 6'h3F
`define SSP_ADDR_MIN 6'h01
`define SSP_ADDR_MAX 6'h3E
`define SSP_REG_DEPTH 64

// ---------------------------------------------------------------
// Register offsets and fields
// ---------------------------------------------------------------
`define SSP_REG_DEV_STATUS 6'h00
`define SSP_REG_ALERT 6'h20
`define SSP_REG_FAULT 6'h21
`define SSP_REG_ADDR 6'h3B
`define SSP_REG_RESET 6'h3C
`define SSP_RSV0_LO 6'h13
`define SSP_RSV0_HI 6'h1F
`define SSP_RSV1_LO 6'h26
`define SSP_RSV1_HI 6'h2F
`define SSP_RSV2_LO 6'h35
`define SSP_RSV2_HI 6'h39
`define SSP_RSV3 6'h3E
`define SSP_AR_BIT 7
`define SSP_FAULT_CRC_BIT 0
`define SSP_RST_ALERT 8'h80
`define SSP_RST_FAULT 8'h08
`define SSP_RESET_KEY 8'hA5

// ---------------------------------------------------------------
// Packet and check byte
// ---------------------------------------------------------------
`define SSP_POLY 8'h07
`define SSP_WR_BYTES 8'h03
`define SSP_WR_BYTES_CRC 8'h04
`define SSP_LEN_BYTE 8'h02

`endif

// [ssp_pkg.sv]
// Types of the stacked serial packet layer.
// Assumes ssp_cfg.svh for numeric constants.
package ssp_pkg;

    // ---------------------------------------------------------------
    // Packet phase
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        SSP_IDLE = 3'b001,
        SSP_RECV = 3'b010,
        SSP_SEND = 3'b100
    } ssp_state_t;

endpackage

// [ssp_buf.sv]
// Small FIFO with valid/ready on both sides.
// Assumes one clock, async active-low reset, clock enable freezing state.
`timescale 1ns/1ps
`default_nettype none
module ssp_buf #(
    parameter int W = 14,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0] cnt_q;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign in_ready = cnt_q < (PW + 1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rp_q];

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            if (push) begin
                wp_q <= nxt(wp_q);
            end
            if (pop) begin
                rp_q <= nxt(rp_q);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + (PW + 1)'(1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - (PW + 1)'(1);
            end
        end
    end
endmodule // ssp_buf
`default_nettype wire

// [ssp_core.sv]
// Packet layer of one device in a stacked serial chain.
// Assumes link pins are asynchronous to CORE_CLK and slow enough to be
// oversampled; ssp_pkg and ssp_buf compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_cfg.svh"
module ssp_core #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic BASE_SEL,
    input wire logic HOST_CS_N,
    input wire logic HOST_SCLK,
    input wire logic HOST_DATA_IN,
    input wire logic SOUTH_CS,
    input wire logic SOUTH_SCLK,
    input wire logic SOUTH_DATA_IN,
    input wire logic NORTH_DATA_IN,
    input wire logic NORTH_ALERT,
    input wire logic CHECK_BYTE_DISABLE,
    input wire logic WR_READY,
    output logic HOST_DATA_OUT,
    output logic HOST_DATA_OE,
    output logic SOUTH_DATA_OUT,
    output logic HOST_ALERT,
    output logic SOUTH_ALERT,
    output logic NORTH_CS,
    output logic NORTH_SCLK,
    output logic NORTH_DATA_OUT,
    output logic FAULT,
    output logic ADDRESS_ASSIGNED_FLAG,
    output logic [5:0] DEVICE_ADDR,
    output logic WR_VALID,
    output logic [5:0] WR_ADDR,
    output logic [7:0] WR_DATA
);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ `SSP_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction

    function automatic logic in_rng(input logic [5:0] a, input logic [5:0] lo,
                                    input logic [5:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [8:0] sync1_q;
    logic [8:0] sync2_q;
    wire [8:0] pins = {NORTH_ALERT, NORTH_DATA_IN, SOUTH_DATA_IN, SOUTH_SCLK, SOUTH_CS,
                       HOST_DATA_IN, HOST_SCLK, HOST_CS_N, BASE_SEL};

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1_q <= 9'h002;
            sync2_q <= 9'h002;
        end else if (CLK_EN) begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    wire base = sync2_q[0];
    wire north_alert = sync2_q[8];
    wire north_din = sync2_q[7];
    // Host select is active low, vertical select active high
    wire cs_act = base ? ~sync2_q[1] : sync2_q[4];
    wire sclk = base ? sync2_q[2] : sync2_q[5];
    wire din = base ? sync2_q[3] : sync2_q[6];

    // ---------------------------------------------------------------
    // Edge detection
    // ---------------------------------------------------------------
    logic cs_prev_q;
    logic sclk_prev_q;

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cs_prev_q <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else if (CLK_EN) begin
            cs_prev_q <= cs_act;
            sclk_prev_q <= sclk;
        end
    end

    wire cs_rise = cs_act & ~cs_prev_q;
    wire cs_fall = ~cs_act & cs_prev_q;
    // Mode 1: sample on falling, shift out on rising
    wire sck_fall = sclk_prev_q & ~sclk & cs_act;
    wire sck_rise = ~sclk_prev_q & sclk & cs_act;

    // ---------------------------------------------------------------
    // Device state registers
    // ---------------------------------------------------------------
    ssp_pkg::ssp_state_t state_q;
    ssp_pkg::ssp_state_t state_d;
    logic [5:0] addr_q;
    logic ar_q;
    logic [7:0] fault_q;
    logic [7:0] regs_q [`SSP_REG_DEPTH];

    wire addr_valid = in_rng(addr_q, `SSP_ADDR_MIN, `SSP_ADDR_MAX);

    // ---------------------------------------------------------------
    // Receiver
    // ---------------------------------------------------------------
    logic [2:0] bit_cnt_q;
    logic [6:0] rx_sr_q;
    logic [7:0] byte_cnt_q;
    logic [7:0] hdr_q;
    logic [7:0] off_q;
    logic [7:0] b2_q;
    logic [7:0] crc_q;

    wire in_pkt = state_q != ssp_pkg::SSP_IDLE;
    wire byte_done = sck_fall & in_pkt & (bit_cnt_q == 3'h7);
    wire [7:0] byte_in = {rx_sr_q, din};
    wire [7:0] crc_next = crc8(crc_q, byte_in);
    wire [5:0] hdr_addr = hdr_q[6:1];
    wire hdr_ok = ~hdr_q[7] & (byte_cnt_q != 8'h00);
    wire is_wr = hdr_q[0];
    wire hit_rd = hdr_ok & ~is_wr & (hdr_addr == addr_q);
    wire bcast_hit = (hdr_addr == `SSP_BCAST) & addr_valid;
    wire hit_wr = hdr_ok & is_wr & ((hdr_addr == addr_q) | bcast_hit);
    wire [7:0] byte_cnt_inc = (byte_cnt_q == 8'hFF) ? byte_cnt_q : byte_cnt_q + 8'h01;

    // Any new select restarts the receiver from bit zero
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bit_cnt_q <= 3'h0;
            rx_sr_q <= 7'h00;
            byte_cnt_q <= 8'h00;
        end else if (CLK_EN) begin
            if (cs_rise) begin
                bit_cnt_q <= 3'h0;
                byte_cnt_q <= 8'h00;
            end else if (sck_fall && in_pkt) begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
                rx_sr_q <= byte_in[6:0];
                if (byte_done) begin
                    byte_cnt_q <= byte_cnt_inc;
                end
            end
        end
    end

    // Header capture and running check; filler after header is excluded
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hdr_q <= 8'h00;
            off_q <= 8'h00;
            b2_q <= 8'h00;
            crc_q <= 8'h00;
        end else if (CLK_EN) begin
            if (cs_rise) begin
                crc_q <= 8'h00;
            end else if (byte_done && state_q == ssp_pkg::SSP_RECV) begin
                crc_q <= crc_next;
                if (byte_cnt_q == 8'h00) begin
                    hdr_q <= byte_in;
                end
                if (byte_cnt_q == 8'h01) begin
                    off_q <= byte_in;
                end
                if (byte_cnt_q == `SSP_LEN_BYTE) begin
                    b2_q <= byte_in;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Packet phase
    // ---------------------------------------------------------------
    wire go_send = byte_done & (byte_cnt_q == `SSP_LEN_BYTE) & hit_rd;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ssp_pkg::SSP_IDLE: if (cs_rise) state_d = ssp_pkg::SSP_RECV;
            ssp_pkg::SSP_RECV: begin
                if (cs_fall) state_d = ssp_pkg::SSP_IDLE;
                else if (go_send) state_d = ssp_pkg::SSP_SEND;
            end
            ssp_pkg::SSP_SEND: if (cs_fall) state_d = ssp_pkg::SSP_IDLE;
            default: state_d = ssp_pkg::SSP_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= ssp_pkg::SSP_IDLE;
        end else if (CLK_EN) begin
            state_q <= state_d;
        end
    end

    // ---------------------------------------------------------------
    // Read data and transmitter
    // ---------------------------------------------------------------
    logic [7:0] tx_sr_q;
    logic [7:0] tx_crc_q;
    logic [8:0] tx_idx_q;
    logic dout_q;

    wire [5:0] rd_addr = off_q[5:0] + tx_idx_q[5:0];
    wire rd_rsv = in_rng(rd_addr, `SSP_RSV0_LO, `SSP_RSV0_HI)
                | in_rng(rd_addr, `SSP_RSV1_LO, `SSP_RSV1_HI)
                | in_rng(rd_addr, `SSP_RSV2_LO, `SSP_RSV2_HI)
                | (rd_addr == `SSP_RSV3) | (rd_addr == `SSP_REG_RESET);
    wire [7:0] ar_field = 8'(ar_q) << `SSP_AR_BIT;
    wire [7:0] rd_data = rd_rsv ? 8'h00
                       : (rd_addr == `SSP_REG_DEV_STATUS) ? ar_field
                       : (rd_addr == `SSP_REG_FAULT) ? fault_q
                       : (rd_addr == `SSP_REG_ADDR) ? (ar_field | {2'b00, addr_q})
                       : regs_q[rd_addr];
    wire tx_load = go_send | (byte_done & state_q == ssp_pkg::SSP_SEND);
    wire [7:0] tx_seed = (state_q == ssp_pkg::SSP_RECV) ? crc_next : tx_crc_q;
    wire [7:0] tx_len = (state_q == ssp_pkg::SSP_RECV) ? byte_in : b2_q;
    wire tx_more = tx_idx_q < {1'b0, tx_len};
    wire tx_crc_turn = (tx_idx_q == {1'b0, tx_len}) & ~CHECK_BYTE_DISABLE;
    wire [7:0] tx_byte = tx_more ? rd_data : tx_crc_turn ? tx_seed : 8'h00;

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_sr_q <= 8'h00;
            tx_crc_q <= 8'h00;
            tx_idx_q <= 9'h000;
            dout_q <= 1'b0;
        end else if (CLK_EN) begin
            if (cs_rise) begin
                tx_idx_q <= 9'h000;
                dout_q <= 1'b0;
            end else if (tx_load) begin
                tx_sr_q <= tx_byte;
                tx_crc_q <= crc8(tx_seed, rd_data);
                if (tx_more || tx_crc_turn) begin
                    tx_idx_q <= tx_idx_q + 9'h001;
                end
            end else if (sck_rise && state_q == ssp_pkg::SSP_SEND) begin
                dout_q <= tx_sr_q[7];
                tx_sr_q <= {tx_sr_q[6:0], 1'b0};
            end
        end
    end

    // ---------------------------------------------------------------
    // End of packet: check and hold the write
    // ---------------------------------------------------------------
    wire wr_end = cs_fall & (state_q == ssp_pkg::SSP_RECV) & hit_wr & (bit_cnt_q == 3'h0);
    wire wr_good = CHECK_BYTE_DISABLE ? (byte_cnt_q == `SSP_WR_BYTES)
                 : (byte_cnt_q == `SSP_WR_BYTES_CRC) & (crc_q == 8'h00);
    wire crc_fail = cs_fall & (state_q == ssp_pkg::SSP_RECV) & hit_wr
                  & ~CHECK_BYTE_DISABLE & ~(wr_good & bit_cnt_q == 3'h0);
    logic pend_q;
    logic [13:0] pend_word_q;
    wire buf_in_ready;
    wire buf_out_valid;
    wire [13:0] buf_out_data;
    wire pop = buf_out_valid & (~WR_VALID | WR_READY);

    // Write waits here until the buffer can take it
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pend_q <= 1'b0;
            pend_word_q <= 14'h0000;
        end else if (CLK_EN) begin
            if (wr_end && wr_good) begin
                pend_q <= 1'b1;
                pend_word_q <= {off_q[5:0], b2_q};
            end else if (buf_in_ready) begin
                pend_q <= 1'b0;
            end
        end
    end

    ssp_buf #(
        .W(14),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .ce(CLK_EN),
        .in_valid(pend_q),
        .in_ready(buf_in_ready),
        .in_data(pend_word_q),
        .out_valid(buf_out_valid),
        .out_ready(~WR_VALID | WR_READY),
        .out_data(buf_out_data)
    );

    // ---------------------------------------------------------------
    // Register update
    // ---------------------------------------------------------------
    wire [5:0] ap_addr = buf_out_data[13:8];
    wire [7:0] ap_data = buf_out_data[7:0];
    wire soft_rst = pop & (ap_addr == `SSP_REG_RESET) & (ap_data == `SSP_RESET_KEY);
    wire ap_fault = pop & (ap_addr == `SSP_REG_FAULT);
    wire [7:0] crc_bit = 8'(1) << `SSP_FAULT_CRC_BIT;
    wire [7:0] fault_base = soft_rst ? `SSP_RST_FAULT : ap_fault ? ap_data : fault_q;
    // A failure in the clearing cycle still sets the flag
    wire [7:0] fault_d = crc_fail ? (fault_base | crc_bit) : fault_base;

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            addr_q <= 6'h00;
            ar_q <= 1'b0;
            fault_q <= `SSP_RST_FAULT;
        end else if (CLK_EN) begin
            fault_q <= fault_d;
            if (soft_rst) begin
                addr_q <= 6'h00;
                ar_q <= 1'b0;
            end else if (pop && ap_addr == `SSP_REG_ADDR) begin
                addr_q <= ap_data[5:0];
                ar_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < `SSP_REG_DEPTH; i++) begin
                regs_q[i] <= (6'(i) == `SSP_REG_ALERT) ? `SSP_RST_ALERT : 8'h00;
            end
        end else if (CLK_EN) begin
            if (soft_rst) begin
                for (int i = 0; i < `SSP_REG_DEPTH; i++) begin
                    regs_q[i] <= (6'(i) == `SSP_REG_ALERT) ? `SSP_RST_ALERT : 8'h00;
                end
            end else if (pop) begin
                regs_q[ap_addr] <= ap_data;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            WR_VALID <= 1'b0;
            WR_ADDR <= 6'h00;
            WR_DATA <= 8'h00;
        end else if (CLK_EN) begin
            if (pop) begin
                WR_VALID <= 1'b1;
                WR_ADDR <= ap_addr;
                WR_DATA <= ap_data;
            end else if (WR_READY) begin
                WR_VALID <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Pin outputs
    // ---------------------------------------------------------------
    wire sending = state_q == ssp_pkg::SSP_SEND;
    wire pass_up = addr_valid & cs_act;
    wire down_bit = sending ? dout_q : (addr_valid & north_din);
    // Alert held while unaddressed, on a bad write, or passed from above
    wire alert_d = north_alert | ~ar_q | fault_q[`SSP_FAULT_CRC_BIT];

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            NORTH_CS <= 1'b0;
            NORTH_SCLK <= 1'b0;
            NORTH_DATA_OUT <= 1'b0;
            SOUTH_DATA_OUT <= 1'b0;
            HOST_DATA_OUT <= 1'b0;
            HOST_DATA_OE <= 1'b0;
            SOUTH_ALERT <= 1'b1;
            HOST_ALERT <= 1'b1;
            FAULT <= 1'b0;
            ADDRESS_ASSIGNED_FLAG <= 1'b0;
            DEVICE_ADDR <= 6'h00;
        end else if (CLK_EN) begin
            NORTH_CS <= pass_up;
            NORTH_SCLK <= pass_up & sclk;
            NORTH_DATA_OUT <= pass_up & din;
            SOUTH_DATA_OUT <= down_bit;
            HOST_DATA_OUT <= down_bit;
            HOST_DATA_OE <= base & cs_act;
            SOUTH_ALERT <= alert_d;
            HOST_ALERT <= alert_d;
            FAULT <= fault_q[`SSP_FAULT_CRC_BIT];
            ADDRESS_ASSIGNED_FLAG <= ar_q;
            DEVICE_ADDR <= addr_q;
        end
    end

endmodule // ssp_core
`default_nettype wire

// [ssp_core_properties.sv]
// Port checks of the packet layer.
// Assumes one clock domain, async active-low reset, base device.
`timescale 1ns/1ps
`default_nettype none
module ssp_core_chk (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic HOST_CS_N,
    input wire logic WR_READY,
    input wire logic HOST_ALERT,
    input wire logic SOUTH_ALERT,
    input wire logic NORTH_CS,
    input wire logic FAULT,
    input wire logic ADDRESS_ASSIGNED_FLAG,
    input wire logic [5:0] DEVICE_ADDR,
    input wire logic WR_VALID,
    input wire logic [5:0] WR_ADDR,
    input wire logic [7:0] WR_DATA
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);
    // ---------------------------------------------------------------
    // Write causes
    // ---------------------------------------------------------------
    wire logic flt_wr = WR_VALID && (WR_ADDR == 6'h21 || WR_ADDR == 6'h3C);
    wire logic adr_wr = WR_VALID && (WR_ADDR == 6'h3B || WR_ADDR == 6'h3C);
    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    chk_north_blocked: assert property (
        DEVICE_ADDR == 6'h00 && $past(DEVICE_ADDR) == 6'h00 |-> !NORTH_CS)
        else $error("north select unaddressed");
    chk_north_follow: assert property (
        (!HOST_CS_N && DEVICE_ADDR != 6'h00) [*5] |-> NORTH_CS)
        else $error("north select missing");
    chk_alert_pair: assert property (HOST_ALERT == SOUTH_ALERT)
        else $error("alerts differ");
    chk_fault_alert: assert property (FAULT [*3] |-> SOUTH_ALERT)
        else $error("fault without alert");
    chk_unassigned_alert: assert property (
        (!ADDRESS_ASSIGNED_FLAG) [*3] |-> SOUTH_ALERT)
        else $error("unassigned without alert");
    chk_wr_hold: assert property (
        WR_VALID && !WR_READY |=> WR_VALID && $stable({WR_ADDR, WR_DATA}))
        else $error("write dropped in stall");
    chk_fault_clear: assert property (
        $fell(FAULT) |-> flt_wr || $past(flt_wr))
        else $error("fault cleared alone");
    chk_addr_source: assert property (
        $changed(DEVICE_ADDR) |-> adr_wr || $past(adr_wr))
        else $error("address changed alone");
    cover property (WR_VALID && !WR_READY);
    cover property ($rose(FAULT));
    cover property ($rose(ADDRESS_ASSIGNED_FLAG));
endmodule // ssp_core_chk
bind ssp_core ssp_core_chk ssp_core_chk_i (.*);
`default_nettype wire

// [ssp_host.sv]
// Host on the serial pins: mode 1 master, MSB first.
// Assumes the bench frames packets with sel and moves bytes with xfer.
`timescale 1ns/1ps
`default_nettype none
module ssp_host (
    output logic cs_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    // ---------------------------------------------------------------
    // Link driving
    // ---------------------------------------------------------------
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b1;
    end
    function automatic logic [7:0] crc8(input logic [7:0] c, b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++)
            r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
        return r;
    endfunction
    task automatic sel(input logic on);
        #400;
        cs_n = ~on;
        mosi = 1'b1;
        #400;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b1;
            mosi = tx[i];
            #200;
            sclk = 1'b0;
            #190;
            rx[i] = miso_oe ? miso : 1'b1; // Pull-up when released
            #10;
        end
    endtask
endmodule // ssp_host
`default_nettype wire

// [ssp_core_test.sv]
// Bench of the packet layer as base device.
// Assumes ssp_host on the host pins, the checker bound in.
`timescale 1ns/1ps
`default_nettype none
module ssp_core_test;
    logic CORE_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic CLK_EN = 1'b1;
    logic BASE_SEL = 1'b1;
    logic SOUTH_CS = 1'b0;
    logic SOUTH_SCLK = 1'b0;
    logic SOUTH_DATA_IN = 1'b0;
    logic NORTH_ALERT = 1'b0;
    logic CHECK_BYTE_DISABLE = 1'b0;
    logic WR_READY = 1'b1;
    wire logic NORTH_DATA_IN = NORTH_ALERT;
    wire logic HOST_CS_N, HOST_SCLK, HOST_DATA_IN, HOST_DATA_OUT, HOST_DATA_OE;
    wire logic SOUTH_DATA_OUT, HOST_ALERT, SOUTH_ALERT, NORTH_CS, NORTH_SCLK;
    wire logic NORTH_DATA_OUT, FAULT, ADDRESS_ASSIGNED_FLAG, WR_VALID;
    wire logic [5:0] DEVICE_ADDR, WR_ADDR;
    wire logic [7:0] WR_DATA;
    int err_count = 0;
    int n_tests = 0;
    logic [15:0] n_up = 16'h0000;
    logic [13:0] wq [$];
    logic [13:0] drain [3] = '{14'h32A1, 14'h33B2, 14'h34C3};
    ssp_core ssp_core_i (.*);
    ssp_host ssp_host_i (.cs_n(HOST_CS_N), .sclk(HOST_SCLK), .mosi(HOST_DATA_IN),
        .miso(HOST_DATA_OUT), .miso_oe(HOST_DATA_OE));
    always #25 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK)
        if (WR_VALID === 1'b1 && WR_READY)
            wq.push_back({WR_ADDR, WR_DATA});
    always @(posedge NORTH_SCLK) n_up++;
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
        #5;
    endtask
    task automatic chk(input logic [15:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: %h not %h", $time, m, got, exp);
        end
    endtask
    task automatic hdr(input logic [23:0] b, output logic [7:0] c);
        logic [7:0] r;
        c = 8'h00;
        ssp_host_i.sel(1'b1);
        for (int i = 2; i >= 0; i--) begin
            c = ssp_host_i.crc8(c, b[i*8+:8]);
            ssp_host_i.xfer(b[i*8+:8], r);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] o, d, input logic bad);
        logic [7:0] c, r;
        hdr({1'b0, a, 1'b1, o, d}, c);
        if (!CHECK_BYTE_DISABLE)
            ssp_host_i.xfer(c ^ {7'h00, bad}, r);
        ssp_host_i.sel(1'b0);
        cyc(8);
    endtask
    task automatic rd(input logic [5:0] a, o, input logic [7:0] exp);
        logic [7:0] c, r;
        hdr({1'b0, a, 1'b0, 2'b00, o, 8'h01}, c);
        ssp_host_i.xfer(8'h00, r);
        chk(r, exp, "rd data");
        c = ssp_host_i.crc8(c, exp);
        if (!CHECK_BYTE_DISABLE) begin
            ssp_host_i.xfer(8'h00, r);
            chk(r, c, "rd crc");
        end
        ssp_host_i.sel(1'b0);
        cyc(8);
    endtask
    task automatic end_sim;
        $display("Checks %0d, errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        cyc(3);
        RESET_N = 1'b1;
        cyc(4);
        chk({SOUTH_ALERT, HOST_ALERT, NORTH_CS, ADDRESS_ASSIGNED_FLAG, DEVICE_ADDR},
            16'h0300, "reset");
        wr(6'h00, 8'h3B, 8'h05, 1'b0);
        chk(wq.pop_front(), {6'h3B, 8'h05}, "addr wr");
        chk({ADDRESS_ASSIGNED_FLAG, DEVICE_ADDR, SOUTH_ALERT}, 16'h008A, "assigned");
        chk(n_up, 16'h0000, "north blocked");
        NORTH_ALERT = 1'b1;
        cyc(8);
        chk(SOUTH_ALERT, 16'h0001, "north alert");
        NORTH_ALERT = 1'b0;
        wr(6'h00, 8'h30, 8'h11, 1'b0);
        chk(wq.size() == 0, 16'h0001, "foreign");
        chk(n_up, 16'h0020, "north clk");
        wr(6'h05, 8'h30, 8'h22, 1'b1);
        chk({FAULT, SOUTH_ALERT, wq.size() == 0}, 16'h0007, "bad crc");
        rd(6'h05, 6'h21, 8'h09);
        chk(FAULT, 16'h0001, "latched");
        wr(6'h05, 8'h21, 8'h00, 1'b0);
        chk({FAULT, wq.pop_front()}, {2'b00, 6'h21, 8'h00}, "clear");
        wr(6'h3F, 8'h31, 8'h12, 1'b0);
        chk(wq.pop_front(), {6'h31, 8'h12}, "bcast");
        rd(6'h05, 6'h31, 8'h12);
        rd(6'h05, 6'h13, 8'h00);
        WR_READY = 1'b0;
        foreach (drain[i])
            wr(6'h05, {2'b00, drain[i][13:8]}, drain[i][7:0], 1'b0);
        chk({WR_VALID, WR_ADDR, WR_DATA}, {1'b1, drain[0]}, "stall");
        WR_READY = 1'b1;
        cyc(8);
        foreach (drain[i])
            chk(wq.pop_front(), drain[i], "drain");
        CHECK_BYTE_DISABLE = 1'b1;
        wr(6'h05, 8'h30, 8'h44, 1'b0);
        chk(wq.pop_front(), {6'h30, 8'h44}, "no crc");
        rd(6'h05, 6'h30, 8'h44);
        wr(6'h05, 8'h3C, 8'hA5, 1'b0);
        chk({ADDRESS_ASSIGNED_FLAG, DEVICE_ADDR, SOUTH_ALERT}, 16'h0001, "soft reset");
        end_sim();
    end
    initial begin
        #1000000; // About five times the planned traffic
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end
endmodule // ssp_core_test
`default_nettype wire
